/* File: common/mon_pkg.sv */
// shared constants and types for the two-wire bus monitor
package mon_pkg;
    // ------------------------------------------------------------
    // byte framing
    // ------------------------------------------------------------
    localparam logic [3:0] BIT_LAST  = 4'h7;  // last data bit slot
    localparam logic [3:0] ACK_SLOT  = 4'h8;  // ninth slot, acknowledge
    localparam logic [3:0] ACK_DONE  = 4'h9;  // ack sampled, await fall
    localparam logic [4:0] TEN_PREFIX = 5'h1e; // 11110 long-address lead
    localparam logic       DIR_READ  = 1'b1;
    // ------------------------------------------------------------
    // direction trigger select
    // ------------------------------------------------------------
    localparam logic [1:0] DSEL_READ   = 2'h1;
    localparam logic [1:0] DSEL_WRITE  = 2'h2;
    localparam logic [1:0] DSEL_EITHER = 2'h3;
    // ------------------------------------------------------------
    // filter enables: bits 0..3 frame types {ten,dir}, 4..5 errors
    // ------------------------------------------------------------
    localparam int         FILT_W       = 6;
    localparam int         EN_NACK      = 4;
    localparam int         EN_INCOMP    = 5;
    localparam logic [5:0] FILT_ALL     = 6'h3f;
    localparam logic [5:0] FILT_NONE    = 6'h00;
    localparam logic [5:0] FILT_DEFAULT = 6'h0f;
    // ------------------------------------------------------------
    // frame record layout
    // ------------------------------------------------------------
    localparam int REC_W        = 24;
    localparam int REC_CNT_LSB  = 0;   // 10-bit data byte count
    localparam int REC_ADDR_LSB = 10;  // 10-bit address
    localparam int REC_ERR_LSB  = 20;  // {incomplete, nack}
    localparam int REC_TYPE_LSB = 22;  // {ten, dir}
    localparam int FIFO_DEPTH   = 32;

    typedef enum {ST_IDLE, ST_BYTE} mon_state_t;
    typedef enum {PH_ADDR1, PH_ADDR2, PH_DATA} addr_phase_t;
    typedef enum logic [1:0] {F_ALL, F_NONE, F_INV, F_DEFAULT} filt_cmd_t;
endpackage

/* File: common/stream_if.sv */
// valid/ready word stream between the monitor and its record fifo
`timescale 1ns/100ps
interface stream_if #(parameter int WIDTH = 24);
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

/* File: rtl/rec_fifo.sv */
// record fifo with registered read stage
`timescale 1ns/100ps
module rec_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 32
) (
    input  wire logic clk,    // sampling clock
    input  wire logic arst_n, // async reset, active low
    stream_if.snk     in_s,   // filling side
    stream_if.src     out_s   // draining side
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      count_reg;
    logic             out_valid_reg;
    logic [WIDTH-1:0] out_data_reg;
    logic             push;
    logic             pop;

    // full refuses pushes; the writer sees ready low and stalls
    assign in_s.ready  = (count_reg != (AW+1)'(DEPTH));
    assign push        = in_s.valid && in_s.ready;
    assign pop         = (count_reg != '0) && (!out_valid_reg || out_s.ready);
    assign out_s.valid = out_valid_reg;
    assign out_s.data  = out_data_reg;

    // storage write
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_s.data;
        end
    end

    // pointers and occupancy
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= AW'((wr_ptr_reg + 1'b1) % DEPTH);
            end
            if (pop) begin
                rd_ptr_reg <= AW'((rd_ptr_reg + 1'b1) % DEPTH);
            end
            count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // output register, refilled when empty or taken
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            out_valid_reg <= 1'b0;
            out_data_reg  <= '0;
        end else if (pop) begin
            out_valid_reg <= 1'b1;
            out_data_reg  <= mem[rd_ptr_reg];
        end else if (out_s.ready) begin
            out_valid_reg <= 1'b0;
        end
    end
endmodule

/* File: rtl/bus_monitor.sv */
// passive two-wire bus monitor: conditions, addresses, triggers, filter
`timescale 1ns/100ps
module bus_monitor #(
    parameter int FIFO_DEPTH = mon_pkg::FIFO_DEPTH
) (
    input  wire logic              clk,            // 25 MHz sampling clock
    input  wire logic              arst_n,         // async reset, low
    input  wire logic              scl_in,         // bus clock line
    input  wire logic              sda_in,         // bus data line
    input  wire logic [1:0]        dir_sel,        // direction qualifier
    input  wire logic [7:0]        pattern,        // data byte to match
    input  wire logic              filt_cmd_valid, // filter command strobe
    input  wire mon_pkg::filt_cmd_t filt_cmd,      // filter command
    input  wire logic              rec_ready,      // record sink ready
    output logic                   trig_start,     // start pulse
    output logic                   trig_rstart,    // repeated start pulse
    output logic                   trig_stop,      // stop pulse
    output logic                   trig_addr,      // address done pulse
    output logic                   trig_dir,       // direction match pulse
    output logic                   trig_nack,      // missing ack pulse
    output logic                   trig_pattern,   // pattern match pulse
    output logic [5:0]             filt_en,        // filter enables
    output logic                   rec_overflow,   // record dropped, sticky
    output logic                   rec_valid,      // record available
    output logic [23:0]            rec_data        // frame record
);
    // ------------------------------------------------------------
    // line synchronisers and condition detect
    // ------------------------------------------------------------
    logic scl_meta_reg, scl_sync_reg, scl_prev_reg;
    logic sda_meta_reg, sda_sync_reg, sda_prev_reg;
    logic scl_rise, scl_fall, start_det, stop_det;

    // meta stage feeds only the sync stage
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            scl_meta_reg <= 1'b1;
            scl_sync_reg <= 1'b1;
            scl_prev_reg <= 1'b1;
            sda_meta_reg <= 1'b1;
            sda_sync_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
        end else begin
            scl_meta_reg <= scl_in;
            scl_sync_reg <= scl_meta_reg;
            scl_prev_reg <= scl_sync_reg;
            sda_meta_reg <= sda_in;
            sda_sync_reg <= sda_meta_reg;
            sda_prev_reg <= sda_sync_reg;
        end
    end

    // clock held high on both samples so a clock edge is never a condition
    assign scl_rise  = scl_sync_reg && !scl_prev_reg;
    assign scl_fall  = !scl_sync_reg && scl_prev_reg;
    assign start_det = scl_sync_reg && scl_prev_reg
                       && sda_prev_reg && !sda_sync_reg;
    assign stop_det  = scl_sync_reg && scl_prev_reg
                       && !sda_prev_reg && sda_sync_reg;

    // ------------------------------------------------------------
    // bit slot tracking
    // ------------------------------------------------------------
    mon_pkg::mon_state_t state_reg;
    logic [3:0]          bit_cnt_reg;
    logic [7:0]          shift_reg;
    logic                byte_done, ack_end, abandon, nack;

    assign byte_done = (state_reg == mon_pkg::ST_BYTE) && scl_rise
                       && (bit_cnt_reg == mon_pkg::ACK_SLOT);
    assign ack_end   = (state_reg == mon_pkg::ST_BYTE) && scl_fall
                       && (bit_cnt_reg == mon_pkg::ACK_DONE);
    // a start or stop inside a frame follows one clock rise; only later rises cut
    assign abandon   = (start_det || stop_det)
                       && (state_reg == mon_pkg::ST_BYTE)
                       && (bit_cnt_reg > 4'h1);
    assign nack      = sda_sync_reg;  // high on ninth pulse

    // shift eight bits, then the ack slot, then wait for its falling edge
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg   <= mon_pkg::ST_IDLE;
            bit_cnt_reg <= '0;
            shift_reg   <= '0;
        end else if (start_det || stop_det) begin
            bit_cnt_reg <= '0;  // partial byte discarded
            state_reg   <= start_det ? mon_pkg::ST_BYTE : mon_pkg::ST_IDLE;
        end else if (state_reg == mon_pkg::ST_BYTE) begin
            if (scl_rise && bit_cnt_reg <= mon_pkg::BIT_LAST) begin
                shift_reg   <= {shift_reg[6:0], sda_sync_reg};
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (byte_done) begin
                bit_cnt_reg <= mon_pkg::ACK_DONE;
            end else if (ack_end) begin
                bit_cnt_reg <= '0;
            end
        end
    end

    // ------------------------------------------------------------
    // message and address decode
    // ------------------------------------------------------------
    mon_pkg::addr_phase_t phase_reg;
    logic       msg_open_reg, ten_reg, dir_reg, addr_pend_reg;
    logic [9:0] addr_reg, byte_cnt_reg;
    logic       err_nack_reg, err_inc_reg, nack_is_err;

    // open from start to stop; a start while open is repeated
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            msg_open_reg <= 1'b0;
        end else if (stop_det) begin
            msg_open_reg <= 1'b0;
        end else if (start_det) begin
            msg_open_reg <= 1'b1;
        end
    end

    // the closing nack of a read is expected, not a fault
    assign nack_is_err = !(phase_reg == mon_pkg::PH_DATA
                           && dir_reg == mon_pkg::DIR_READ);

    // long-address state survives a repeated start so the read form pairs
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            phase_reg     <= mon_pkg::PH_ADDR1;
            ten_reg       <= 1'b0;
            dir_reg       <= 1'b0;
            addr_reg      <= '0;
            addr_pend_reg <= 1'b0;
            byte_cnt_reg  <= '0;
            err_nack_reg  <= 1'b0;
            err_inc_reg   <= 1'b0;
        end else if (stop_det) begin
            phase_reg     <= mon_pkg::PH_ADDR1;
            ten_reg       <= 1'b0;
            addr_pend_reg <= 1'b0;
            byte_cnt_reg  <= '0;
            err_nack_reg  <= 1'b0;
            err_inc_reg   <= 1'b0;
        end else if (start_det) begin
            phase_reg     <= mon_pkg::PH_ADDR1;
            addr_pend_reg <= 1'b0;
            if (!msg_open_reg) begin
                ten_reg      <= 1'b0;
                byte_cnt_reg <= '0;
                err_nack_reg <= 1'b0;
                err_inc_reg  <= 1'b0;
            end else if (abandon) begin
                err_inc_reg <= 1'b1;
            end
        end else if (byte_done) begin
            if (nack && nack_is_err) begin
                err_nack_reg <= 1'b1;
            end
            case (phase_reg)
                mon_pkg::PH_ADDR1: begin
                    dir_reg <= shift_reg[0];
                    if (shift_reg[7:3] == mon_pkg::TEN_PREFIX
                        && shift_reg[0] != mon_pkg::DIR_READ) begin
                        ten_reg       <= 1'b1;
                        addr_reg[9:8] <= shift_reg[2:1];
                        phase_reg     <= mon_pkg::PH_ADDR2;
                    end else if (shift_reg[7:3] == mon_pkg::TEN_PREFIX
                                 && ten_reg
                                 && shift_reg[2:1] == addr_reg[9:8]) begin
                        addr_pend_reg <= 1'b1;
                        phase_reg     <= mon_pkg::PH_DATA;
                    end else begin
                        ten_reg       <= 1'b0;
                        addr_reg      <= {3'h0, shift_reg[7:1]};
                        addr_pend_reg <= 1'b1;
                        phase_reg     <= mon_pkg::PH_DATA;
                    end
                end
                mon_pkg::PH_ADDR2: begin
                    addr_reg[7:0] <= shift_reg;
                    addr_pend_reg <= 1'b1;
                    phase_reg     <= mon_pkg::PH_DATA;
                end
                mon_pkg::PH_DATA: begin
                    byte_cnt_reg <= byte_cnt_reg + 10'h001;
                end
                default: begin
                    phase_reg <= mon_pkg::PH_ADDR1;
                end
            endcase
        end else if (ack_end) begin
            addr_pend_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // trigger pulses, one cycle each
    // ------------------------------------------------------------
    logic dir_hit;

    assign dir_hit = (dir_reg == mon_pkg::DIR_READ)
                     ? (dir_sel == mon_pkg::DSEL_READ
                        || dir_sel == mon_pkg::DSEL_EITHER)
                     : (dir_sel == mon_pkg::DSEL_WRITE
                        || dir_sel == mon_pkg::DSEL_EITHER);

    // registered so every trigger leaves straight from a flop
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            trig_start   <= 1'b0;
            trig_rstart  <= 1'b0;
            trig_stop    <= 1'b0;
            trig_addr    <= 1'b0;
            trig_dir     <= 1'b0;
            trig_nack    <= 1'b0;
            trig_pattern <= 1'b0;
        end else begin
            trig_start   <= start_det && !msg_open_reg;
            trig_rstart  <= start_det && msg_open_reg;
            trig_stop    <= stop_det;
            trig_addr    <= ack_end && addr_pend_reg;
            trig_dir     <= ack_end && addr_pend_reg && dir_hit;
            trig_nack    <= byte_done && nack && nack_is_err;
            trig_pattern <= byte_done
                            && phase_reg == mon_pkg::PH_DATA
                            && shift_reg == pattern;
        end
    end

    // ------------------------------------------------------------
    // frame filter
    // ------------------------------------------------------------
    // frame passes if its type is on and each error it carries is on
    function automatic logic frame_pass(input logic [1:0] ftype,
                                        input logic [1:0] errs,
                                        input logic [5:0] en);
        logic type_ok;
        logic err_ok;
        type_ok = en[ftype];
        err_ok  = (!errs[0] || en[mon_pkg::EN_NACK])
                  && (!errs[1] || en[mon_pkg::EN_INCOMP]);
        return type_ok && err_ok;
    endfunction

    // bulk commands act on frame and error enables together
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            filt_en <= mon_pkg::FILT_DEFAULT;
        end else if (filt_cmd_valid) begin
            case (filt_cmd)
                mon_pkg::F_ALL:     filt_en <= mon_pkg::FILT_ALL;
                mon_pkg::F_NONE:    filt_en <= mon_pkg::FILT_NONE;
                mon_pkg::F_INV:     filt_en <= ~filt_en;
                mon_pkg::F_DEFAULT: filt_en <= mon_pkg::FILT_DEFAULT;
                default:            filt_en <= filt_en;
            endcase
        end
    end

    // ------------------------------------------------------------
    // record push into the fifo
    // ------------------------------------------------------------
    stream_if #(.WIDTH(mon_pkg::REC_W)) push_s ();
    stream_if #(.WIDTH(mon_pkg::REC_W)) pop_s ();
    logic       push_valid_reg;
    logic [23:0] push_data_reg;
    logic [1:0]  rec_err;
    logic        rec_pass;

    assign rec_err  = {err_inc_reg || abandon, err_nack_reg};
    assign rec_pass = frame_pass({ten_reg, dir_reg}, rec_err, filt_en);
    assign push_s.valid = push_valid_reg;
    assign push_s.data  = push_data_reg;
    assign pop_s.ready  = rec_ready;

    // one slot of holding; a frame ending while it waits is dropped
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            push_valid_reg <= 1'b0;
            push_data_reg  <= '0;
            rec_overflow   <= 1'b0;
        end else if (stop_det && msg_open_reg && rec_pass) begin
            if (push_valid_reg && !push_s.ready) begin
                rec_overflow <= 1'b1;
            end else begin
                push_valid_reg <= 1'b1;
                push_data_reg  <= {ten_reg, dir_reg, rec_err,
                                   addr_reg, byte_cnt_reg};
            end
        end else if (push_valid_reg && push_s.ready) begin
            push_valid_reg <= 1'b0;
        end
    end

    rec_fifo #(
        .WIDTH (mon_pkg::REC_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk    (clk),
        .arst_n (arst_n),
        .in_s   (push_s),
        .out_s  (pop_s)
    );

    assign rec_valid = pop_s.valid;
    assign rec_data  = pop_s.data;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    sequence s_sda_fall_scl_hi;
        scl_sync_reg && scl_prev_reg && sda_prev_reg && !sda_sync_reg;
    endsequence
    sequence s_sda_rise_scl_hi;
        scl_sync_reg && scl_prev_reg && !sda_prev_reg && sda_sync_reg;
    endsequence

    a_start_pulse: assert property (
        s_sda_fall_scl_hi |=> (trig_start || trig_rstart) ##1
                              !(trig_start || trig_rstart))
        else $error("start condition not flagged for exactly one cycle");
    a_stop_close: assert property (
        s_sda_rise_scl_hi |=> trig_stop && !msg_open_reg)
        else $error("stop did not pulse or did not close message");
    a_rstart_open: assert property (
        trig_rstart |-> $past(msg_open_reg) && !trig_start)
        else $error("repeated start flagged outside open message");
    a_abandon_idle: assert property (
        abandon |=> bit_cnt_reg == 4'h0)
        else $error("partial byte not abandoned on condition");
    a_addr_timing: assert property (
        trig_addr |-> $past(scl_fall) && $past(bit_cnt_reg) == 4'h9)
        else $error("address trigger not at ack falling edge");
    a_dir_write: assert property (
        trig_dir && dir_sel == mon_pkg::DSEL_WRITE |-> !dir_reg && trig_addr)
        else $error("write qualifier fired on a read");
    a_read_nack_ok: assert property (
        byte_done && nack && phase_reg == mon_pkg::PH_DATA && dir_reg
        |=> !trig_nack)
        else $error("closing read nack reported as missing ack");
    a_nack_pulse: assert property (
        byte_done && nack && phase_reg == mon_pkg::PH_ADDR2 |=> trig_nack)
        else $error("missing ack on address byte not flagged");
    a_filt_invert: assert property (
        filt_cmd_valid && filt_cmd == mon_pkg::F_INV
        |=> filt_en == ~$past(filt_en))
        else $error("invert command did not flip every enable");
    a_push_typed: assert property (
        $rose(push_valid_reg) |-> $past(filt_en[{ten_reg, dir_reg}]))
        else $error("frame pushed with its type disabled");
endmodule

/* File: verif/bus_ctrl_model.sv */
// behavioural bus controller and target driving the monitored lines
`timescale 1ns/100ps
module bus_ctrl_model (
    output logic scl, // bus clock, idle high
    output logic sda  // bus data, pulled up
);
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    // start or stop; clock stands high outside frames
    task automatic cond(input logic is_stop);
        sda = !is_stop;
        #80 scl = 1'b1;
        #160 sda = is_stop;
        #160 scl = is_stop;
    endtask
    // one bit slot, data changed only while clock is low
    task automatic bit_slot(input logic b);
        sda = b;
        #80 scl = 1'b1;
        #160 scl = 1'b0;
        #80;
    endtask
    // msb first, then the receiver's ack slot
    task automatic xfer(input logic [7:0] b, input logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_slot(b[i]);
        end
        bit_slot(ack);
    endtask
endmodule

/* File: verif/tb_top.sv */
// self-checking bench for the two-wire bus monitor
`timescale 1ns/100ps
module tb_top;
    typedef struct packed {
        logic [7:0]  ab;   // first byte
        logic [7:0]  db;   // second byte
        logic        dack; // ack after second byte
        logic [1:0]  dsel; // direction select
        logic [7:0]  pat;  // pattern
        logic [27:0] cnt;  // start,rstart,stop,addr,dir,nack,pat
        logic [23:0] rec;  // last record, zero if none
    } row_t;
    logic clk, arst_n, fcv, rec_ready, clr, scl, sda;
    logic t_s, t_r, t_p, t_a, t_d, t_n, t_m, rec_overflow, rec_valid;
    logic [1:0] dir_sel;
    logic [7:0] pattern, nrec;
    logic [5:0] filt_en;
    logic [23:0] rec_data, last;
    logic [27:0] cnt;
    mon_pkg::filt_cmd_t fcmd;
    int bad_count = 0;
    int n_checks = 0;
    row_t rows [7] = '{
        '{8'ha0, 8'h41, 1'b0, 2'h2, 8'h41, 28'h1011101, 24'h014001},
        '{8'ha1, 8'h33, 1'b1, 2'h1, 8'h41, 28'h1011100, 24'h414001},
        '{8'ha0, 8'h41, 1'b1, 2'h1, 8'h41, 28'h1011011, 24'h000000},
        '{8'ha1, 8'h00, 1'b1, 2'h3, 8'hff, 28'h1011100, 24'h414001},
        '{8'ha0, 8'h41, 1'b0, 2'h0, 8'h41, 28'h1011001, 24'h014001},
        '{8'hf2, 8'h34, 1'b0, 2'h2, 8'h34, 28'h1011100, 24'h84d000},
        '{8'hf2, 8'h34, 1'b1, 2'h1, 8'h34, 28'h1011010, 24'h000000}};
    logic [5:0] fexp [4] = '{6'h3f, 6'h00, 6'h3f, 6'h0f};
    bus_ctrl_model bus_ctrl_model_inst (.scl(scl), .sda(sda));
    bus_monitor #(.FIFO_DEPTH(4)) bus_monitor_inst (
        .clk(clk), .arst_n(arst_n), .scl_in(scl), .sda_in(sda),
        .dir_sel(dir_sel), .pattern(pattern), .filt_cmd_valid(fcv),
        .filt_cmd(fcmd), .rec_ready(rec_ready), .trig_start(t_s),
        .trig_rstart(t_r), .trig_stop(t_p), .trig_addr(t_a),
        .trig_dir(t_d), .trig_nack(t_n), .trig_pattern(t_m),
        .filt_en(filt_en), .rec_overflow(rec_overflow),
        .rec_valid(rec_valid), .rec_data(rec_data));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // one nibble per trigger; pulses never exceed 15 per test
    always @(posedge clk) begin
        if (clr) begin
            cnt <= '0;
            last <= '0;
            nrec <= '0;
        end else begin
            cnt <= cnt + {3'h0, t_s, 3'h0, t_r, 3'h0, t_p, 3'h0, t_a,
                          3'h0, t_d, 3'h0, t_n, 3'h0, t_m};
            if (rec_valid && rec_ready) begin
                last <= rec_data;
                nrec <= nrec + 8'h01;
            end
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic final_report;
        $display("checks=%0d mismatches=%0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic clear;
        @(negedge clk) clr = 1'b1;
        @(negedge clk) clr = 1'b0;
    endtask
    initial begin
        #3000000;
        bad_count++;
        final_report;
    end
    initial begin
        {arst_n, fcv, clr, dir_sel, pattern} = '0;
        fcmd = mon_pkg::F_ALL;
        rec_ready = 1'b1;
        repeat (8) @(negedge clk);
        check({filt_en, t_s, t_p, rec_valid, rec_overflow}, 10'h0f0);
        arst_n = 1'b1;
        repeat (4) @(negedge clk);
        $display("reset done");
        // table of single frames
        foreach (rows[i]) begin
            dir_sel = rows[i].dsel;
            pattern = rows[i].pat;
            clear;
            bus_ctrl_model_inst.cond(1'b0);
            bus_ctrl_model_inst.xfer(rows[i].ab, 1'b0);
            bus_ctrl_model_inst.xfer(rows[i].db, rows[i].dack);
            bus_ctrl_model_inst.cond(1'b1);
            repeat (12) @(negedge clk);
            check(cnt, rows[i].cnt);
            check(last, rows[i].rec);
            $display("row %0d done", i);
        end
        // long read through a repeated start
        clear;
        bus_ctrl_model_inst.cond(1'b0);
        bus_ctrl_model_inst.xfer(8'hf2, 1'b0);
        bus_ctrl_model_inst.xfer(8'h34, 1'b0);
        bus_ctrl_model_inst.cond(1'b0);
        bus_ctrl_model_inst.xfer(8'hf3, 1'b0);
        bus_ctrl_model_inst.xfer(8'h55, 1'b1);
        bus_ctrl_model_inst.cond(1'b1);
        repeat (12) @(negedge clk);
        check(cnt[27:16], 12'h111);
        check(last, 24'hc4d001);
        $display("long read done");
        // sink stalled: fifo, output stage and holding slot fill, then drop
        rec_ready = 1'b0;
        clear;
        repeat (8) begin
            bus_ctrl_model_inst.cond(1'b0);
            bus_ctrl_model_inst.xfer(8'ha0, 1'b0);
            bus_ctrl_model_inst.cond(1'b1);
        end
        check(rec_overflow, 1'b1);
        rec_ready = 1'b1;
        repeat (20) @(negedge clk);
        check(nrec, 8'h06);
        $display("overflow done");
        // bulk filter commands, back to back
        // strobe held high so no signal is assigned twice in one step
        fcv = 1'b1;
        for (int i = 0; i < 4; i++) begin
            fcmd = mon_pkg::filt_cmd_t'(i);
            @(negedge clk);
            check(filt_en, fexp[i]);
        end
        fcv = 1'b0;
        $display("filter done");
        // reset in mid-run clears the sticky drop flag
        arst_n = 1'b0;
        @(negedge clk);
        check({filt_en, rec_overflow, rec_valid, t_p}, 9'h078);
        arst_n = 1'b1;
        repeat (4) @(negedge clk);
        $display("mid-run reset done");
        // frame cut by a stop after three bits: no record by default
        clear;
        bus_ctrl_model_inst.cond(1'b0);
        bus_ctrl_model_inst.bit_slot(1'b1);
        bus_ctrl_model_inst.bit_slot(1'b0);
        bus_ctrl_model_inst.bit_slot(1'b1);
        bus_ctrl_model_inst.cond(1'b1);
        repeat (12) @(negedge clk);
        check(cnt, 28'h1010000);
        check(nrec, 8'h00);
        $display("cut frame done");
        final_report;
    end
endmodule
